/* hw/fcs_pkg.sv */
// shared constants, command encodings and carrier types of the flash command host
package fcs_pkg;

  // clock rate and bus timing, times in their own unit
  localparam int CLK_MHZ        = 125;
  localparam int T_ADDR_SETUP_NS = 10;
  localparam int T_STROBE_NS    = 50;
  localparam int T_STROBE_HI_NS = 30;
  localparam int T_READ_ACC_NS  = 90;
  localparam int SECT_LOAD_US   = 100;
  localparam int LOAD_GUARD_CYC = 64;

  // least times round up to whole cycles
  function automatic int ns2cyc(int ns);
    return (ns * CLK_MHZ + 999) / 1000;
  endfunction

  localparam logic [3:0] SETUP_CYC  = 4'(ns2cyc(T_ADDR_SETUP_NS));
  localparam logic [3:0] STROBE_CYC = 4'(ns2cyc(T_STROBE_NS));
  localparam logic [3:0] HIGH_CYC   = 4'(ns2cyc(T_STROBE_HI_NS));
  localparam logic [3:0] ACC_CYC    = 4'(ns2cyc(T_READ_ACC_NS));
  localparam int         SECT_LOAD_CYC = SECT_LOAD_US * CLK_MHZ;
  localparam int         MAX_SECTORS   = 19;

  // unlock addresses and command bytes
  localparam logic [19:0] ADDR_UNLOCK1    = 20'h00555;
  localparam logic [19:0] ADDR_UNLOCK2    = 20'h002aa;
  localparam logic [19:0] ADDR_ANY        = 20'h00000;
  localparam logic [7:0]  CMD_UNLOCK1     = 8'haa;
  localparam logic [7:0]  CMD_UNLOCK2     = 8'h55;
  localparam logic [7:0]  CMD_READ_RESET  = 8'hf0;
  localparam logic [7:0]  CMD_IDENT       = 8'h90;
  localparam logic [7:0]  CMD_PROGRAM     = 8'ha0;
  localparam logic [7:0]  CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0]  CMD_CHIP_ERASE  = 8'h10;
  localparam logic [7:0]  CMD_SECTOR      = 8'h30;
  localparam logic [7:0]  CMD_SUSPEND     = 8'hb0;
  localparam logic [7:0]  CMD_RESUME      = 8'h30;

  // status bit positions in the polled byte
  localparam int DATA_POLL_BIT = 7;
  localparam int LIMIT_BIT     = 5;

  typedef enum logic [3:0] {
    OP_RESET1, OP_RESET3, OP_IDENT, OP_PROGRAM, OP_CHIP_ERASE,
    OP_SECT_ERASE, OP_ADD_SECT, OP_SUSPEND, OP_RESUME, OP_READ
  } fcs_op_t;

  typedef enum {PH_IDLE, PH_SETUP, PH_STROBE, PH_HIGH, PH_READ} fcs_phase_t;
  typedef enum {S_IDLE, S_SEQ, S_READ, S_POLL, S_LOAD, S_SUSP} fcs_state_t;

  typedef struct packed {
    logic        wr;
    logic [19:0] addr;
    logic [7:0]  data;
  } fcs_cyc_t;

  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [19:0] addr;
    logic [7:0]  dq_o;
    logic        dq_oe;
  } fcs_pins_t;

  typedef struct packed {
    fcs_phase_t phase;
    logic [3:0] cnt;
    logic       wr;
    logic       ce_mode;
    fcs_pins_t  pins;
    logic [7:0] rdata;
    logic       done;
  } fcs_bus_st_t;

  typedef struct packed {
    fcs_state_t  state;
    fcs_op_t     op;
    logic [2:0]  step;
    logic [19:0] addr;
    logic [7:0]  data;
    logic        exp7;
    logic        recheck;
    logic        after_err;
    logic        ret_susp;
    logic [4:0]  sect_cnt;
    logic [15:0] timer;
    logic        cyc_start;
    logic        cyc_busy;
    fcs_cyc_t    cyc;
    logic        rsp_valid;
    logic        rsp_err;
    logic [7:0]  rsp_data;
  } fcs_top_st_t;

  // index of the last bus cycle of each command sequence
  function automatic logic [2:0] seq_last(fcs_op_t op);
    unique case (op)
      OP_RESET3, OP_IDENT:          return 3'd2;
      OP_PROGRAM:                   return 3'd3;
      OP_CHIP_ERASE, OP_SECT_ERASE: return 3'd5;
      default:                      return 3'd0;
    endcase
  endfunction

  // address and data of one write of a command sequence
  function automatic fcs_cyc_t seq_entry(fcs_op_t op, logic [2:0] step, logic [19:0] a, logic [7:0] d);
    fcs_cyc_t c;
    c.wr   = 1'b1;
    c.addr = ADDR_UNLOCK1;
    c.data = CMD_UNLOCK1;
    case (step)
      3'd1, 3'd4: begin
        c.addr = ADDR_UNLOCK2;
        c.data = CMD_UNLOCK2;
      end
      3'd2: begin
        c.data = (op == OP_RESET3) ? CMD_READ_RESET : (op == OP_IDENT) ? CMD_IDENT :
                 (op == OP_PROGRAM) ? CMD_PROGRAM : CMD_ERASE_SETUP;
      end
      3'd3: begin
        if (op == OP_PROGRAM) begin
          c.addr = a;
          c.data = d;
        end
      end
      3'd5: begin
        c.data = (op == OP_CHIP_ERASE) ? CMD_CHIP_ERASE : CMD_SECTOR;
        if (op == OP_SECT_ERASE) begin
          c.addr = a;
        end
      end
      default: begin
        unique case (op)
          OP_RESET1:  c = '{wr: 1'b1, addr: ADDR_ANY, data: CMD_READ_RESET};
          OP_ADD_SECT: c = '{wr: 1'b1, addr: a, data: CMD_SECTOR};
          OP_SUSPEND: c = '{wr: 1'b1, addr: ADDR_ANY, data: CMD_SUSPEND};
          OP_RESUME:  c = '{wr: 1'b1, addr: ADDR_ANY, data: CMD_RESUME};
          default:    c = c;
        endcase
      end
    endcase
    return c;
  endfunction

endpackage

/* hw/fcs_bus_cycle.sv */
// one asynchronous write or read cycle on the flash pins
`timescale 1ns/10ps
module fcs_bus_cycle
  import fcs_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       start_i,
  input  wire fcs_cyc_t   cyc_i,
  input  wire logic       ce_ctl_i,
  input  wire logic [7:0] dq_i,
  output fcs_pins_t       pins_o,
  output logic            done_o,
  output logic [7:0]      rdata_o
);

  if (SETUP_CYC == 4'h0 || STROBE_CYC == 4'h0 || HIGH_CYC == 4'h0 || ACC_CYC == 4'h0) begin : g_chk
    $error("bus phase counts must be between 1 and 15");
  end

  fcs_bus_st_t s_q;
  fcs_bus_st_t s_d;

  // phase sequencer; the strobe is we_n, or ce_n when ce-controlled
  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    unique case (s_q.phase)
      PH_IDLE: begin
        if (start_i) begin
          s_d.wr         = cyc_i.wr;
          s_d.ce_mode    = ce_ctl_i;
          s_d.pins.addr  = cyc_i.addr;
          s_d.pins.dq_o  = cyc_i.data;
          s_d.pins.dq_oe = cyc_i.wr;
          s_d.pins.oe_n  = cyc_i.wr;
          if (cyc_i.wr) begin
            s_d.phase     = PH_SETUP;
            s_d.cnt       = SETUP_CYC;
            s_d.pins.we_n = !ce_ctl_i;
            s_d.pins.ce_n = ce_ctl_i;
          end else begin
            s_d.phase     = PH_READ;
            s_d.cnt       = ACC_CYC;
            s_d.pins.ce_n = 1'b0;
          end
        end
      end
      PH_SETUP: begin
        s_d.cnt = s_q.cnt - 4'h1;
        if (s_q.cnt == 4'h1) begin
          // address is stable before the falling strobe edge
          s_d.phase = PH_STROBE;
          s_d.cnt   = STROBE_CYC;
          if (s_q.ce_mode) begin
            s_d.pins.ce_n = 1'b0;
          end else begin
            s_d.pins.we_n = 1'b0;
          end
        end
      end
      PH_STROBE: begin
        s_d.cnt = s_q.cnt - 4'h1;
        if (s_q.cnt == 4'h1) begin
          // rising strobe latches the data, so data is held into PH_HIGH
          s_d.phase     = PH_HIGH;
          s_d.cnt       = HIGH_CYC;
          s_d.pins.ce_n = 1'b1;
          s_d.pins.we_n = 1'b1;
        end
      end
      PH_HIGH: begin
        s_d.cnt = s_q.cnt - 4'h1;
        if (s_q.cnt == 4'h1) begin
          s_d.phase      = PH_IDLE;
          s_d.pins.dq_oe = 1'b0;
          s_d.done       = 1'b1;
        end
      end
      PH_READ: begin
        s_d.cnt = s_q.cnt - 4'h1;
        if (s_q.cnt == 4'h1) begin
          s_d.phase     = PH_IDLE;
          s_d.rdata     = dq_i;
          s_d.pins.ce_n = 1'b1;
          s_d.pins.oe_n = 1'b1;
          s_d.done      = 1'b1;
        end
      end
    endcase
  end

  // state register, pins parked deselected during reset
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_q       <= '0;
      s_q.phase <= PH_IDLE;
      s_q.pins  <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 20'h00000, dq_o: 8'h00, dq_oe: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign pins_o  = s_q.pins;
  assign done_o  = s_q.done;
  assign rdata_o = s_q.rdata;

  a_ce_style_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.phase == PH_STROBE && s_q.ce_mode) |-> (!s_q.pins.we_n && !s_q.pins.ce_n && s_q.pins.oe_n))
    else $error("ce-controlled write lost we low or oe high");

  a_addr_data_stable: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.phase == PH_STROBE && $past(s_q.phase) == PH_STROBE) |->
      ($stable(s_q.pins.addr) && $stable(s_q.pins.dq_o) && s_q.pins.dq_oe))
    else $error("address or data moved while strobe low");

endmodule

/* hw/fcs_flash_host.sv */
// host-side command sequencer for a byte-wide parallel flash
// Behaviour
// - writes: ce low, oe high, address before we falls, data held past rise
// - optional ce-controlled writes: we held low, ce pulsed as strobe
// - read mode via f0 anywhere, or aa/555, 55/2aa, f0/555
// - program is three unlocks ending a0/555, then target address and value
// - chip erase is six writes ending 10/555
// - sector erase sixth write is 30 to an address in the sector
// - extra sectors within 100 us each; erase begins 100 us later
// - suspend is b0 anywhere, only while sector erase is running; the host also issues it during the sector load window
`timescale 1ns/10ps
module fcs_flash_host
  import fcs_pkg::*;
#(
  parameter int SECT_LOAD_CYC_P = SECT_LOAD_CYC,
  parameter int MAX_SECT_P      = MAX_SECTORS
) (
  input  wire logic        CLOCK_I,
  input  wire logic        RST_N_I,
  input  wire logic        REQ_VALID_I,
  output logic             REQ_READY_O,
  input  wire fcs_op_t     REQ_OP_I,
  input  wire logic [19:0] REQ_ADDR_I,
  input  wire logic [7:0]  REQ_DATA_I,
  input  wire logic        CE_CTL_I,
  output logic             RSP_VALID_O,
  output logic             RSP_ERR_O,
  output logic [7:0]       RSP_DATA_O,
  output logic             BUSY_O,
  output logic             SUSPENDED_O,
  output logic [19:0]      FL_ADDR_O,
  input  wire logic [7:0]  FL_DQ_I,
  output logic [7:0]       FL_DQ_O,
  output logic             FL_DQ_OE_O,
  output logic             FL_CE_N_O,
  output logic             FL_OE_N_O,
  output logic             FL_WE_N_O
);

  if (SECT_LOAD_CYC_P <= LOAD_GUARD_CYC || SECT_LOAD_CYC_P > 65535 || MAX_SECT_P < 1 || MAX_SECT_P > 31) begin : g_chk
    $error("load window must fit 16 bits above the guard, sectors 1 to 31");
  end

  localparam logic [15:0] LOAD_END  = 16'(SECT_LOAD_CYC_P);
  localparam logic [15:0] LOAD_LAST = 16'(SECT_LOAD_CYC_P - LOAD_GUARD_CYC);
  localparam logic [4:0]  SECT_MAX  = 5'(MAX_SECT_P);

  fcs_top_st_t s_q;
  fcs_top_st_t s_d;
  fcs_pins_t   pins;
  logic        cyc_done;
  logic [7:0]  cyc_rdata;
  logic        accept;
  logic        strobe;

  fcs_bus_cycle u_cycle (
    .clk_i   (CLOCK_I),
    .rst_n_i (RST_N_I),
    .start_i (s_q.cyc_start),
    .cyc_i   (s_q.cyc),
    .ce_ctl_i(CE_CTL_I),
    .dq_i    (FL_DQ_I),
    .pins_o  (pins),
    .done_o  (cyc_done),
    .rdata_o (cyc_rdata)
  );

  // requests are taken only between bus cycles, so no request overlaps a bus cycle in flight
  assign REQ_READY_O = (s_q.state inside {S_IDLE, S_POLL, S_LOAD, S_SUSP}) && !s_q.cyc_busy && !s_q.cyc_start;
  assign accept      = REQ_VALID_I && REQ_READY_O;
  assign strobe      = !pins.we_n && !pins.ce_n;

  // command sequencer
  always_comb begin
    s_d           = s_q;
    s_d.cyc_start = 1'b0;
    s_d.rsp_valid = 1'b0;
    s_d.rsp_err   = 1'b0;
    if (s_q.cyc_start) begin
      s_d.cyc_busy = 1'b1;
    end
    if (cyc_done) begin
      s_d.cyc_busy = 1'b0;
    end
    unique case (s_q.state)
      S_IDLE: begin
        if (accept) begin
          s_d.op   = REQ_OP_I;
          s_d.addr = REQ_ADDR_I;
          s_d.data = REQ_DATA_I;
          s_d.step = 3'd0;
          unique case (REQ_OP_I)
            OP_READ: begin
              // plain array read, flash sits in read mode after reset
              s_d.state     = S_READ;
              s_d.ret_susp  = 1'b0;
              s_d.cyc       = '{wr: 1'b0, addr: REQ_ADDR_I, data: 8'h00};
              s_d.cyc_start = 1'b1;
            end
            OP_ADD_SECT, OP_SUSPEND, OP_RESUME: begin
              s_d.rsp_valid = 1'b1;
              s_d.rsp_err   = 1'b1;
            end
            default: s_d.state = S_SEQ;
          endcase
        end
      end
      S_SEQ: begin
        if (!s_q.cyc_busy && !s_q.cyc_start) begin
          s_d.cyc       = seq_entry(s_q.op, s_q.step, s_q.addr, s_q.data);
          s_d.cyc_start = 1'b1;
        end
        if (cyc_done && s_q.step != seq_last(s_q.op)) begin
          s_d.step = s_q.step + 3'd1;
        end else if (cyc_done) begin
          unique case (s_q.op)
            OP_IDENT: begin
              s_d.state     = S_READ;
              s_d.ret_susp  = 1'b0;
              s_d.cyc       = '{wr: 1'b0, addr: {19'h00000, s_q.addr[0]}, data: 8'h00};
              s_d.cyc_start = 1'b1;
            end
            OP_PROGRAM: begin
              s_d.state   = S_POLL;
              s_d.exp7    = s_q.data[DATA_POLL_BIT];
              s_d.recheck = 1'b0;
            end
            OP_CHIP_ERASE: begin
              s_d.state   = S_POLL;
              s_d.exp7    = 1'b1;
              s_d.addr    = ADDR_ANY;
              s_d.recheck = 1'b0;
            end
            OP_SECT_ERASE, OP_ADD_SECT: begin
              // timer restarts after every sector write
              s_d.state     = S_LOAD;
              s_d.timer     = 16'h0000;
              s_d.exp7      = 1'b1;
              s_d.recheck   = 1'b0;
              s_d.sect_cnt  = (s_q.op == OP_ADD_SECT) ? s_q.sect_cnt + 5'd1 : 5'd1;
              s_d.rsp_valid = (s_q.op == OP_ADD_SECT);
            end
            OP_SUSPEND: begin
              s_d.state     = S_SUSP;
              s_d.rsp_valid = 1'b1;
            end
            OP_RESUME: begin
              s_d.state     = S_POLL;
              s_d.rsp_valid = 1'b1;
            end
            default: begin
              // read/reset done; flags a failed run if it was the recovery reset
              s_d.state     = S_IDLE;
              s_d.rsp_valid = 1'b1;
              s_d.rsp_err   = s_q.after_err;
              s_d.after_err = 1'b0;
            end
          endcase
        end
      end
      S_READ: begin
        if (cyc_done) begin
          s_d.state     = s_q.ret_susp ? S_SUSP : S_IDLE;
          s_d.rsp_valid = 1'b1;
          s_d.rsp_data  = cyc_rdata;
        end
      end
      S_POLL: begin
        if (accept) begin
          // only suspend may interrupt, and only a sector erase
          if (REQ_OP_I == OP_SUSPEND && s_q.sect_cnt != 5'd0) begin
            s_d.op    = OP_SUSPEND;
            s_d.step  = 3'd0;
            s_d.state = S_SEQ;
          end else begin
            s_d.rsp_valid = 1'b1;
            s_d.rsp_err   = 1'b1;
          end
        end else if (cyc_done) begin
          if (cyc_rdata[DATA_POLL_BIT] == s_q.exp7) begin
            s_d.state     = S_IDLE;
            s_d.sect_cnt  = 5'd0;
            s_d.rsp_valid = 1'b1;
            s_d.rsp_data  = cyc_rdata;
          end else if (cyc_rdata[LIMIT_BIT] && s_q.recheck) begin
            // second look still not done: failed run, reset the flash
            s_d.op        = OP_RESET1;
            s_d.step      = 3'd0;
            s_d.after_err = 1'b1;
            s_d.sect_cnt  = 5'd0;
            s_d.state     = S_SEQ;
          end else begin
            // poll bit may change with the limit flag, so read once more
            s_d.recheck = cyc_rdata[LIMIT_BIT];
          end
        end else if (!s_q.cyc_busy && !s_q.cyc_start) begin
          s_d.cyc       = '{wr: 1'b0, addr: s_q.addr, data: 8'h00};
          s_d.cyc_start = 1'b1;
        end
      end
      S_LOAD: begin
        if (s_q.timer != LOAD_END) begin
          s_d.timer = s_q.timer + 16'h0001;
        end
        if (accept && REQ_OP_I == OP_ADD_SECT && s_q.sect_cnt < SECT_MAX && s_q.timer < LOAD_LAST) begin
          s_d.op    = OP_ADD_SECT;
          s_d.addr  = REQ_ADDR_I;
          s_d.step  = 3'd0;
          s_d.state = S_SEQ;
        end else if (accept && REQ_OP_I == OP_SUSPEND) begin
          s_d.op    = OP_SUSPEND;
          s_d.step  = 3'd0;
          s_d.state = S_SEQ;
        end else if (accept) begin
          s_d.rsp_valid = 1'b1;
          s_d.rsp_err   = 1'b1;
        end else if (s_q.timer == LOAD_END) begin
          // window closed, erase now runs; status flags poll from here
          s_d.state = S_POLL;
        end
      end
      S_SUSP: begin
        if (accept && REQ_OP_I == OP_READ) begin
          s_d.state     = S_READ;
          s_d.ret_susp  = 1'b1;
          s_d.cyc       = '{wr: 1'b0, addr: REQ_ADDR_I, data: 8'h00};
          s_d.cyc_start = 1'b1;
        end else if (accept && REQ_OP_I == OP_RESUME) begin
          s_d.op    = OP_RESUME;
          s_d.step  = 3'd0;
          s_d.state = S_SEQ;
        end else if (accept) begin
          s_d.rsp_valid = 1'b1;
          s_d.rsp_err   = 1'b1;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      s_q       <= '0;
      s_q.state <= S_IDLE;
      s_q.op    <= OP_READ;
    end else begin
      s_q <= s_d;
    end
  end

  assign RSP_VALID_O = s_q.rsp_valid;
  assign RSP_ERR_O   = s_q.rsp_err;
  assign RSP_DATA_O  = s_q.rsp_data;
  assign BUSY_O      = (s_q.state != S_IDLE);
  assign SUSPENDED_O = (s_q.state == S_SUSP);
  assign FL_ADDR_O   = pins.addr;
  assign FL_DQ_O     = pins.dq_o;
  assign FL_DQ_OE_O  = pins.dq_oe;
  assign FL_CE_N_O   = pins.ce_n;
  assign FL_OE_N_O   = pins.oe_n;
  assign FL_WE_N_O   = pins.we_n;

  a_write_oe_high: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    strobe |-> (FL_OE_N_O && FL_DQ_OE_O))
    else $error("write strobe while outputs enabled");

  a_reset_one_cycle: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    (accept && s_q.state == S_IDLE && REQ_OP_I == OP_RESET1) |-> ##[1:30] (strobe && FL_DQ_O == CMD_READ_RESET))
    else $error("single-cycle reset did not write f0");

  a_program_setup: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    (accept && s_q.state == S_IDLE && REQ_OP_I == OP_PROGRAM) |->
      ##[1:200] (strobe && FL_DQ_O == CMD_PROGRAM && FL_ADDR_O == ADDR_UNLOCK1))
    else $error("program setup a0 to 555 not written");

  a_chip_erase_cmd: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    (accept && s_q.state == S_IDLE && REQ_OP_I == OP_CHIP_ERASE) |->
      ##[1:300] (strobe && FL_DQ_O == CMD_CHIP_ERASE && FL_ADDR_O == ADDR_UNLOCK1))
    else $error("chip erase sixth cycle missing");

  a_sector_cmd_addr: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    (accept && s_q.state == S_IDLE && REQ_OP_I == OP_SECT_ERASE) |->
      ##[1:300] (strobe && FL_DQ_O == CMD_SECTOR && FL_ADDR_O == s_q.addr))
    else $error("sector command not written to the sector address");

  a_load_window: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    ($rose(s_q.state == S_SEQ) && s_q.op == OP_ADD_SECT) |-> $past(s_q.timer) < LOAD_LAST)
    else $error("extra sector started too late in the load window");

  a_suspend_gate: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    (accept && REQ_OP_I == OP_SUSPEND && s_q.state inside {S_IDLE, S_SUSP}) |=> (s_q.state != S_SEQ && RSP_ERR_O))
    else $error("suspend issued with no sector erase running");

  a_erase_only_suspend: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    (accept && s_q.state == S_POLL && REQ_OP_I != OP_SUSPEND) |=> (s_q.state == S_POLL && RSP_VALID_O && RSP_ERR_O))
    else $error("command other than suspend let through during erase");

endmodule

/* sim/fcs_flash_model.sv */
// behavioural flash device behind the host pins
`timescale 1ns/10ps
module fcs_flash_model #(
  parameter logic [7:0] MAKER_CODE = 8'h5c, // arbitrary value
  parameter logic [7:0] PART_CODE  = 8'hc5, // arbitrary value
  parameter int         BUSY_CYC   = 60
) (
  input  wire logic        clk_i,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic [19:0] addr_i,
  input  wire logic [7:0]  dq_i,
  output logic [7:0]       dq_o
);
  logic [7:0]  mem [0:1048575];
  logic [19:0] la_q;
  logic [7:0]  pv_q = 8'hff;
  logic        str_q = 1'b1, ident_q = 1'b0, fail_q = 1'b0, sect_q = 1'b0, susp_q = 1'b0;
  int          step_q = 0, busy_q = 0;
  wire         str_n = ce_n_i | we_n_i | ~oe_n_i;

  initial for (int i = 0; i < 1048576; i++) mem[i] = 8'hff;
  initial dq_o = 8'h00;

  // sector chosen by upper address bits, wiped at once
  task automatic wipe(logic [6:0] s);
    for (int i = 0; i < 8192; i++) mem[{s, 13'(i)}] = 8'hff;
  endtask

  // command interpreter, one call per rising strobe
  task automatic cmd(logic [19:0] a, logic [7:0] d);
    if (fail_q && d == 8'hf0) begin // only a reset leaves a failed program
      fail_q = 1'b0;
      busy_q = 0;
    end
    if (susp_q && d == 8'h30) begin
      susp_q = 1'b0;
      return;
    end
    if (sect_q && busy_q > 0 && d == 8'hb0) begin
      susp_q = 1'b1;
      return;
    end
    if (sect_q && busy_q > 0 && d == 8'h30) begin
      wipe(a[19:13]);
      busy_q = BUSY_CYC;
      return;
    end
    // any other write abandons the sector erase, sectors left invalid
    if (sect_q && busy_q > 0) begin
      sect_q = 1'b0;
      susp_q = 1'b0;
      busy_q = 0;
    end
    if (busy_q > 0) return;
    sect_q = 1'b0;
    case (step_q)
      0: begin
        if (d == 8'hf0) ident_q = 1'b0;
        step_q = (a == 20'h00555 && d == 8'haa) ? 1 : 0;
      end
      1, 4: step_q = (a == 20'h002aa && d == 8'h55) ? step_q + 1 : 0;
      2: begin
        step_q = 0;
        if (a == 20'h00555 && d == 8'hf0) ident_q = 1'b0;
        if (a == 20'h00555 && d == 8'h90) ident_q = 1'b1;
        if (a == 20'h00555 && d == 8'ha0) step_q = 6;
        if (a == 20'h00555 && d == 8'h80) step_q = 3;
      end
      3: step_q = (a == 20'h00555 && d == 8'haa) ? 4 : 0;
      5: begin
        step_q = 0;
        pv_q = 8'hff;
        busy_q = BUSY_CYC;
        sect_q = (d == 8'h30);
        if (d == 8'h30) wipe(a[19:13]);
        else if (a == 20'h00555 && d == 8'h10) for (int i = 0; i < 128; i++) wipe(7'(i));
        else busy_q = 0;
      end
      default: begin
        step_q = 0;
        pv_q = d;
        fail_q = |(d & ~mem[a]);
        mem[a] = mem[a] & d;
        busy_q = BUSY_CYC;
      end
    endcase
  endtask

  // address on falling strobe, data on rising strobe
  always @(posedge clk_i) begin
    if (!str_n && str_q) la_q = addr_i;
    if (str_n && !str_q) cmd(la_q, dq_i);
    else if (busy_q > 0 && !fail_q && !susp_q) busy_q--;
    str_q = str_n;
  end

  // output moves mid-cycle so the host edge never races it
  always @(negedge clk_i) begin
    if (ce_n_i || oe_n_i) dq_o = ~dq_o; // released bus keeps no stale value
    else if (busy_q > 0 && !susp_q) dq_o = {~pv_q[7], 1'b0, fail_q, 5'h00};
    else if (ident_q) dq_o = addr_i[0] ? PART_CODE : MAKER_CODE;
    else dq_o = mem[addr_i];
  end
endmodule

/* sim/tb_fcs_flash_host.sv */
// self-checking bench of the flash command host
`timescale 1ns/10ps
module tb_fcs_flash_host import fcs_pkg::*;;
  localparam logic [7:0] MAKER = 8'h5c; // arbitrary value
  localparam logic [7:0] PART  = 8'hc5; // arbitrary value
  logic        clk = 1'b0, rst_n = 1'b0, valid = 1'b0, ce_ctl = 1'b0;
  fcs_op_t     op = OP_READ;
  logic [19:0] addr = 20'h00000, fl_addr;
  logic [7:0]  data = 8'h00, dq_in, dq_out, rdata, bus;
  logic        ready, rv, rerr, dq_oe, ce_n, oe_n, we_n, busy, susp;
  int          num_errors = 0, n_tests = 0;

  always #4 clk = ~clk;
  assign bus = dq_oe ? dq_out : dq_in;

  fcs_flash_host #(.SECT_LOAD_CYC_P(200), .MAX_SECT_P(19)) u_dut (.CLOCK_I(clk), .RST_N_I(rst_n),
    .REQ_VALID_I(valid), .REQ_READY_O(ready), .REQ_OP_I(op), .REQ_ADDR_I(addr), .REQ_DATA_I(data),
    .CE_CTL_I(ce_ctl), .RSP_VALID_O(rv), .RSP_ERR_O(rerr), .RSP_DATA_O(rdata), .BUSY_O(busy),
    .SUSPENDED_O(susp), .FL_ADDR_O(fl_addr), .FL_DQ_I(bus), .FL_DQ_O(dq_out), .FL_DQ_OE_O(dq_oe),
    .FL_CE_N_O(ce_n), .FL_OE_N_O(oe_n), .FL_WE_N_O(we_n));
  fcs_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) u_flash (.clk_i(clk), .ce_n_i(ce_n),
    .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(fl_addr), .dq_i(bus), .dq_o(dq_in));

  task automatic chk(logic [7:0] got, logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until taken at a ready edge
  task automatic put(fcs_op_t o, logic [19:0] a, logic [7:0] d);
    @(posedge clk);
    op <= o;
    addr <= a;
    data <= d;
    valid <= 1'b1;
    repeat (2000) begin
      @(negedge clk);
      if (ready === 1'b1) break;
    end
    chk({7'h00, ready}, 8'h01);
    @(posedge clk);
    valid <= 1'b0;
  endtask

  // bounded wait for the answer pulse, then judge it
  task automatic ans(logic e_err, logic [7:0] e_dat, logic use_d);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rv !== 1'b1 && n < 20000);
    chk({7'h00, rv}, 8'h01);
    chk({7'h00, rerr}, {7'h00, e_err});
    if (use_d) chk(rdata, e_dat);
  endtask

  task automatic run(fcs_op_t o, logic [19:0] a, logic [7:0] d, logic e_err, logic [7:0] e_dat, logic use_d);
    put(o, a, d);
    ans(e_err, e_dat, use_d);
  endtask

  task automatic t_program;
    run(OP_READ, 20'h01234, 8'h00, 1'b0, 8'hff, 1'b1);
    run(OP_PROGRAM, 20'h12345, 8'h5a, 1'b0, 8'h00, 1'b0);
    run(OP_READ, 20'h12345, 8'h00, 1'b0, 8'h5a, 1'b1);
    @(posedge clk) ce_ctl <= 1'b1;
    run(OP_PROGRAM, 20'h12346, 8'h3c, 1'b0, 8'h00, 1'b0);
    @(posedge clk) ce_ctl <= 1'b0;
    run(OP_READ, 20'h12346, 8'h00, 1'b0, 8'h3c, 1'b1);
    run(OP_PROGRAM, 20'h12345, 8'hff, 1'b1, 8'h00, 1'b0);
    run(OP_READ, 20'h12345, 8'h00, 1'b0, 8'h5a, 1'b1);
  endtask

  task automatic t_ident;
    run(OP_IDENT, 20'hfff00, 8'h00, 1'b0, MAKER, 1'b1);
    run(OP_IDENT, 20'habc01, 8'h00, 1'b0, PART, 1'b1);
    run(OP_RESET1, 20'h00000, 8'h00, 1'b0, 8'h00, 1'b0);
    run(OP_READ, 20'h12346, 8'h00, 1'b0, 8'h3c, 1'b1);
    run(OP_RESET3, 20'h00000, 8'h00, 1'b0, 8'h00, 1'b0);
  endtask

  task automatic t_erase;
    run(OP_SUSPEND, 20'h00000, 8'h00, 1'b1, 8'h00, 1'b0);
    put(OP_SECT_ERASE, 20'h12000, 8'h00);
    run(OP_ADD_SECT, 20'h40000, 8'h00, 1'b0, 8'h00, 1'b0);
    ans(1'b0, 8'h00, 1'b0);
    run(OP_READ, 20'h12345, 8'h00, 1'b0, 8'hff, 1'b1);
    run(OP_PROGRAM, 20'h80010, 8'h00, 1'b0, 8'h00, 1'b0);
    run(OP_CHIP_ERASE, 20'h00000, 8'h00, 1'b0, 8'h00, 1'b0);
    run(OP_READ, 20'h80010, 8'h00, 1'b0, 8'hff, 1'b1);
  endtask

  // refusals while polling, then an erase suspended, read around and resumed
  task automatic t_suspend;
    put(OP_PROGRAM, 20'h70000, 8'h12);
    run(OP_READ, 20'h70000, 8'h00, 1'b1, 8'h00, 1'b0);
    ans(1'b0, 8'h00, 1'b0);
    put(OP_SECT_ERASE, 20'h60000, 8'h00);
    run(OP_SUSPEND, 20'h00000, 8'h00, 1'b0, 8'h00, 1'b0);
    chk({7'h00, susp}, 8'h01);
    run(OP_READ, 20'h70000, 8'h00, 1'b0, 8'h12, 1'b1);
    run(OP_PROGRAM, 20'h70001, 8'h00, 1'b1, 8'h00, 1'b0);
    run(OP_RESUME, 20'h00000, 8'h00, 1'b0, 8'h00, 1'b0);
    chk({7'h00, susp}, 8'h00);
    chk({7'h00, busy}, 8'h01);
    run(OP_READ, 20'h70000, 8'h00, 1'b1, 8'h00, 1'b0);
    ans(1'b0, 8'h00, 1'b0);
    chk({7'h00, busy}, 8'h00);
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog sized well above the expected run
  initial begin
    #(8 * 90000);
    num_errors++;
    end_sim;
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_program;
    t_ident;
    t_erase;
    t_suspend;
    end_sim;
  end
endmodule
